/* File: hw/unc_ep0_ctrl.sv */
// Strobed register access was decided locally.
module unc_ep0_ctrl (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register bus
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // serial engine
   input wire unc_pkg::unc_sie_t i_sie,
   input wire logic i_rx_empty_read,
   output unc_pkg::unc_hs_t o_hs,
   // fifo controls
   output logic o_rx_clear,
   output logic o_tx_clear,
   // interrupt
   output logic o_irq
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_STAT = 2'b11
   } unc_xfer_t;

   typedef struct packed {
      unc_xfer_t xfer;
      logic in_ready;
      logic out_nak;
      logic ovr;
      logic seen_setup;
      logic [7:0] evt;
      logic [7:0] mask;
      logic [7:0] rdata;
      logic rx_clear;
      logic tx_clear;
   } unc_st_t;

   unc_st_t st_reg, st_next;
   logic nak_all;
   logic busy;
   logic sync_point;
   logic na_wr;
   logic nak_in_now;

   // byte select of a single bit
   function automatic logic [7:0] bit_at(input int pos, input logic v);
      logic [7:0] r;
      r = 8'h00;
      r[pos] = v;
      return r;
   endfunction

   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      return a == b;
   endfunction

   assign busy = (st_reg.xfer != ST_IDLE);
   assign sync_point = !st_reg.seen_setup || i_sie.setup_pid || i_sie.status_stage;
   assign na_wr = i_wr && hit(i_addr, unc_pkg::NAK_ALL_ADDR);
   assign nak_in_now = i_sie.in_token && o_hs.nak_in;

   unc_nak_all u_nak_all (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_wr(na_wr),
      .i_val(i_wdata[unc_pkg::NAK_ALL_BIT]),
      .i_busy(busy),
      .i_auto_access(i_sie.auto_access),
      .i_sync_point(sync_point),
      .i_nak_in_now(nak_in_now),
      .o_nak_all(nak_all)
   );

   // next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.rx_clear = 1'b0;
      st_next.tx_clear = 1'b0;
      st_next.rdata = 8'h00;
      // transfer tracking
      if (i_sie.bus_reset) begin
         st_next.xfer = ST_IDLE;
         st_next.seen_setup = 1'b0;
      end else if (i_sie.setup_pid) begin
         st_next.xfer = ST_DATA;
         st_next.seen_setup = 1'b1;
      end else if (i_sie.status_stage) begin
         st_next.xfer = ST_STAT;
      end else if (i_sie.xfer_end) begin
         st_next.xfer = ST_IDLE;
      end
      // zero written to flag-clear bit clears the flag
      if (i_wr && hit(i_addr, unc_pkg::INT_CLR_ADDR) && !i_wdata[unc_pkg::OVR_CLR_BIT]) begin
         st_next.ovr = 1'b0;
      end
      // setup during transfer sets flag, wins over clear
      if (i_sie.setup_pid && busy) begin
         st_next.ovr = 1'b1;
         st_next.evt[unc_pkg::EV_OVR] = 1'b1;
      end
      // firmware register writes
      if (i_wr && hit(i_addr, unc_pkg::CTRL_NAK_ADDR)) begin
         st_next.in_ready = i_wdata[unc_pkg::IN_READY_BIT];
         st_next.out_nak = i_wdata[unc_pkg::OUT_NAK_BIT];
      end
      if (i_wr && hit(i_addr, unc_pkg::INT_MASK_ADDR)) begin
         st_next.mask = i_wdata;
      end
      if (i_wr && hit(i_addr, unc_pkg::DATA_END_ADDR) && i_wdata[unc_pkg::DATA_END_BIT]) begin
         st_next.in_ready = 1'b1;
      end
      if (i_wr && hit(i_addr, unc_pkg::FIFO_CTRL_ADDR)) begin
         st_next.rx_clear = i_wdata[unc_pkg::RX_CLR_BIT];
         st_next.tx_clear = i_wdata[unc_pkg::TX_CLR_BIT];
         if (i_wdata[unc_pkg::RX_CLR_BIT]) begin
            st_next.out_nak = 1'b0;
         end
         if (i_wdata[unc_pkg::TX_CLR_BIT]) begin
            st_next.in_ready = 1'b0;
         end
      end
      if (i_rx_empty_read) begin
         st_next.out_nak = 1'b0;
      end
      if (i_sie.out_ok) begin
         st_next.out_nak = 1'b1;
         st_next.evt[unc_pkg::EV_RXDONE] = 1'b1;
      end
      // in data acked, in-ready falls
      if (i_sie.in_acked) begin
         st_next.in_ready = 1'b0;
         st_next.evt[unc_pkg::EV_TXDONE] = 1'b1;
      end
      if (i_sie.nak_sent && nak_all) begin
         st_next.evt[unc_pkg::EV_NAKALL] = 1'b1;
      end
      // register reads, data one cycle later
      if (i_rd) begin
         unique case (i_addr)
            unc_pkg::NAK_ALL_ADDR: st_next.rdata = bit_at(unc_pkg::NAK_ALL_BIT, nak_all);
            unc_pkg::CTRL_NAK_ADDR:
               st_next.rdata = bit_at(unc_pkg::IN_READY_BIT, st_reg.in_ready)
                  | bit_at(unc_pkg::OUT_NAK_BIT, st_reg.out_nak);
            unc_pkg::INT_STAT_ADDR: st_next.rdata = bit_at(unc_pkg::OVR_BIT, st_reg.ovr);
            unc_pkg::INT_MASK_ADDR: st_next.rdata = st_reg.mask;
            unc_pkg::EVT_STAT_ADDR: begin
               st_next.rdata = st_reg.evt;
               // read clears; events this cycle survive
               st_next.evt = st_next.evt & ~st_reg.evt;
               if (i_sie.setup_pid && busy) begin
                  st_next.evt[unc_pkg::EV_OVR] = 1'b1;
               end
               if (i_sie.out_ok) begin
                  st_next.evt[unc_pkg::EV_RXDONE] = 1'b1;
               end
               if (i_sie.in_acked) begin
                  st_next.evt[unc_pkg::EV_TXDONE] = 1'b1;
               end
               if (i_sie.nak_sent && nak_all) begin
                  st_next.evt[unc_pkg::EV_NAKALL] = 1'b1;
               end
            end
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '{xfer: ST_IDLE, in_ready: 1'b0, out_nak: 1'b0, ovr: 1'b0,
                     seen_setup: 1'b0, evt: unc_pkg::EV_RST, mask: 8'h00,
                     rdata: 8'h00, rx_clear: 1'b0, tx_clear: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // handshake decisions
   always_comb begin
      // nak-all forces nak; in-ready sends tx data
      o_hs.nak_in = nak_all || !st_reg.in_ready;
      o_hs.send_in = !nak_all && st_reg.in_ready;
      o_hs.nak_out = nak_all || st_reg.out_nak;
   end

   assign o_rdata = st_reg.rdata;
   assign o_rx_clear = st_reg.rx_clear;
   assign o_tx_clear = st_reg.tx_clear;
   assign o_irq = |(st_reg.evt & st_reg.mask);

   // overwrite flag sets on setup within a transfer
   sequence s_setup_busy;
      busy && i_sie.setup_pid;
   endsequence
   ovr_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
      s_setup_busy |=> st_reg.ovr) else $error("overwrite flag not set");
   ovr_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == unc_pkg::INT_CLR_ADDR && !i_wdata[0] && !i_sie.setup_pid)
      |=> !st_reg.ovr) else $error("overwrite flag not cleared");
   data_end_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == unc_pkg::DATA_END_ADDR && i_wdata[0] && !i_sie.in_acked)
      |=> st_reg.in_ready) else $error("data-end did not set in-ready");
   in_send_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_reg.in_ready && !nak_all) |-> o_hs.send_in) else $error("in data not sent");
   nak_force_a: assert property (@(posedge i_clk) disable iff (i_rst)
      nak_all |-> (o_hs.nak_in && o_hs.nak_out && !o_hs.send_in))
      else $error("nak-all not forcing nak");
   rx_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == unc_pkg::FIFO_CTRL_ADDR && i_wdata[0] && !i_sie.out_ok)
      |=> !st_reg.out_nak) else $error("rx clear kept out-nak");
   rx_empty_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rx_empty_read && !i_sie.out_ok) |=> !st_reg.out_nak) else $error("out-nak stuck");
   out_ok_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_sie.out_ok |=> st_reg.out_nak ##0 o_hs.nak_out) else $error("out-nak not set");
   na_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == unc_pkg::NAK_ALL_ADDR) |=> o_rdata[7:1] == 7'h00 && o_rdata[0] == $past(nak_all))
      else $error("nak-all readback wrong");
endmodule

/* File: hw/unc_pkg.sv */
package unc_pkg;
   // register map
   localparam logic [15:0] NAK_ALL_ADDR = 16'hff61;
   localparam logic [15:0] CTRL_NAK_ADDR = 16'hff60;
   localparam logic [15:0] INT_STAT_ADDR = 16'hff70;
   localparam logic [15:0] INT_CLR_ADDR = 16'hff71;
   localparam logic [15:0] DATA_END_ADDR = 16'hff72;
   localparam logic [15:0] FIFO_CTRL_ADDR = 16'hff73;
   localparam logic [15:0] INT_MASK_ADDR = 16'hff74;
   localparam logic [15:0] EVT_STAT_ADDR = 16'hff75;
   // field positions
   localparam int NAK_ALL_BIT = 0;
   localparam int IN_READY_BIT = 0;
   localparam int OUT_NAK_BIT = 1;
   localparam int OVR_BIT = 0;
   localparam int OVR_CLR_BIT = 0;
   localparam int DATA_END_BIT = 0;
   localparam int RX_CLR_BIT = 0;
   localparam int TX_CLR_BIT = 1;
   // event status bits
   localparam int EV_OVR = 0;
   localparam int EV_RXDONE = 1;
   localparam int EV_TXDONE = 2;
   localparam int EV_NAKALL = 3;
   // reset values
   localparam logic [7:0] NAK_ALL_RST = 8'h00;
   localparam logic [7:0] EV_RST = 8'h00;

   // serial engine events toward the control logic
   typedef struct packed {
      logic setup_pid;    // setup token pid seen
      logic in_token;     // in token to ep0
      logic out_token;    // out token to ep0
      logic out_ok;       // ep0 data received correctly
      logic in_acked;     // ep0 data acked by host
      logic status_stage; // entry to status stage
      logic xfer_end;     // control transfer complete
      logic auto_access;  // engine reads automatic-request data
      logic bus_reset;    // usb bus reset
      logic nak_sent;     // nak being returned to in token
   } unc_sie_t;

   // handshake decisions toward the engine
   typedef struct packed {
      logic nak_in;
      logic nak_out;
      logic send_in;
   } unc_hs_t;

   // register bus request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } unc_bus_t;
endpackage

/* File: hw/unc_nak_all.sv */
// nak-all bit with pending set/clear arbitration
module unc_nak_all (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // firmware write
   input wire logic i_wr,
   input wire logic i_val,
   // engine state
   input wire logic i_busy,
   input wire logic i_auto_access,
   input wire logic i_sync_point,
   input wire logic i_nak_in_now,
   // bit value
   output logic o_nak_all
);
   typedef struct packed {
      logic bit_v;
      logic pend_set;
      logic pend_clr;
   } unc_na_t;
   unc_na_t st_reg, st_next;

   // pending request resolution
   always_comb begin
      st_next = st_reg;
      if (i_wr) begin
         st_next.pend_set = i_val;
         st_next.pend_clr = !i_val;
      end
      if (!i_auto_access) begin
         // set immediately when idle; else at sync points
         if (st_next.pend_set && (!i_busy || i_sync_point)) begin
            st_next.bit_v = 1'b1;
            st_next.pend_set = 1'b0;
         end
         // clear deferred while naking an in token
         if (st_next.pend_clr && !i_nak_in_now) begin
            st_next.bit_v = 1'b0;
            st_next.pend_clr = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_nak_all = st_reg.bit_v;

   // idle set lands in one cycle
   property p_idle_set;
      @(posedge i_clk) disable iff (i_rst)
         (i_wr && i_val && !i_busy && !i_auto_access) |=> o_nak_all;
   endproperty
   idle_set_a: assert property (p_idle_set) else $error("idle set not applied");
   // no change while engine accesses
   access_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_auto_access |=> $stable(o_nak_all)) else $error("nak-all changed during access");
   // no rise mid-transfer without a sync point
   busy_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_busy && !i_sync_point && !o_nak_all) |=> !o_nak_all)
      else $error("nak-all set outside sync point");
   // clear deferred while naking in
   clr_defer_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_nak_all && i_nak_in_now) |=> o_nak_all) else $error("clear not deferred");
endmodule

/* File: test/unc_host_model.sv */
// serial engine side: token and stage events toward the control logic
module unc_host_model (
   // clock
   input wire logic i_clk,
   // handshake decisions from the block
   input wire unc_pkg::unc_hs_t i_hs,
   // engine events
   output unc_pkg::unc_sie_t o_sie,
   output logic o_rx_empty_read
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [10:0] pulse_reg = 11'h000;
   logic [9:0] level_reg = 10'h000;
   logic nak_seen = 1'b0;
   // pulses last one cycle, levels hold until changed
   assign o_sie = unc_pkg::unc_sie_t'(pulse_reg[9:0] | level_reg);
   assign o_rx_empty_read = pulse_reg[10];
   // register each cycle whether a standing in token is being refused, one cycle late
   always @(posedge i_clk) begin
      nak_seen <= level_reg[8] & i_hs.nak_in;
   end
   task automatic pulse(input logic [10:0] m);
      @(posedge i_clk) pulse_reg <= m;
      @(posedge i_clk) pulse_reg <= 11'h000;
   endtask
   task automatic hold(input logic [9:0] m);
      @(posedge i_clk) level_reg <= m;
   endtask
endmodule

/* File: test/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [10:0] SETUP = 11'h200;
   localparam logic [10:0] IN_TOK = 11'h100;
   localparam logic [10:0] OUT_OK = 11'h040;
   localparam logic [10:0] STATUS = 11'h010;
   localparam logic [10:0] XEND = 11'h008;
   localparam logic [10:0] AUTO = 11'h004;
   localparam logic [10:0] RX_EMPTY = 11'h400;
   localparam logic [10:0] BUS_RST = 11'h002;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] rdata;
   unc_pkg::unc_sie_t serial_interface_engine;
   unc_pkg::unc_hs_t hs;
   logic rx_empty_read;
   logic rx_clear;
   logic tx_clear;
   logic irq;
   int fail_count = 0;
   int compares = 0;

   unc_ep0_ctrl i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_sie(serial_interface_engine), .i_rx_empty_read(rx_empty_read),
      .o_hs(hs), .o_rx_clear(rx_clear), .o_tx_clear(tx_clear), .o_irq(irq));
   unc_host_model i_host (.i_clk(i_clk), .i_hs(hs), .o_sie(serial_interface_engine),
      .o_rx_empty_read(rx_empty_read));

   // clock at 20 MHz
   initial begin
      forever #25 i_clk = ~i_clk;
   end

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk) begin
         i_addr <= a;
         i_wdata <= d;
         i_wr <= 1'b1;
      end
      @(posedge i_clk) i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
      @(posedge i_clk) begin
         i_addr <= a;
         i_rd <= 1'b1;
      end
      @(posedge i_clk) i_rd <= 1'b0;
      #1 check(name, exp, rdata);
   endtask

   task automatic t_reset;
      rd(unc_pkg::NAK_ALL_ADDR, 8'h00, "nak_all");
      rd(unc_pkg::CTRL_NAK_ADDR, 8'h00, "ctrl_nak");
      check("hs", 8'h04, {5'h00, hs});
      rd(16'hff7f, 8'h00, "unmapped");
   endtask
   task automatic t_idle_set;
      wr(unc_pkg::NAK_ALL_ADDR, 8'hff);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h01, "nak_all");
      check("hs", 8'h06, {5'h00, hs});
      wr(unc_pkg::NAK_ALL_ADDR, 8'h00);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h00, "nak_all");
   endtask
   task automatic t_pend_busy;
      i_host.pulse(SETUP);
      wr(unc_pkg::NAK_ALL_ADDR, 8'h01);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h00, "nak_all");
      i_host.pulse(STATUS);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h01, "nak_all");
      i_host.pulse(XEND);
      wr(unc_pkg::NAK_ALL_ADDR, 8'h00);
   endtask
   task automatic t_auto;
      i_host.hold(AUTO[9:0]);
      wr(unc_pkg::NAK_ALL_ADDR, 8'h01);
      repeat (2) @(posedge i_clk);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h00, "nak_all");
      i_host.hold(10'h000);
      repeat (2) @(posedge i_clk);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h01, "nak_all");
      wr(unc_pkg::NAK_ALL_ADDR, 8'h00);
   endtask
   task automatic t_overwrite;
      wr(unc_pkg::INT_MASK_ADDR, 8'h01);
      i_host.pulse(SETUP);
      i_host.pulse(SETUP);
      rd(unc_pkg::INT_STAT_ADDR, 8'h01, "overwrite");
      check("irq", 8'h01, {7'h00, irq});
      rd(unc_pkg::EVT_STAT_ADDR, 8'h01, "events");
      check("irq", 8'h00, {7'h00, irq});
      wr(unc_pkg::INT_CLR_ADDR, 8'h00);
      rd(unc_pkg::INT_STAT_ADDR, 8'h00, "overwrite");
      i_host.pulse(XEND);
      wr(unc_pkg::INT_MASK_ADDR, 8'h00);
   endtask
   task automatic t_in_ready;
      rd(unc_pkg::INT_STAT_ADDR, 8'h00, "overwrite");
      wr(unc_pkg::DATA_END_ADDR, 8'h01);
      rd(unc_pkg::CTRL_NAK_ADDR, 8'h01, "ctrl_nak");
      check("nak_in", 8'h00, {7'h00, hs.nak_in});
      wr(unc_pkg::FIFO_CTRL_ADDR, 8'h02);
      #1 check("tx_clear", 8'h01, {7'h00, tx_clear});
      rd(unc_pkg::CTRL_NAK_ADDR, 8'h00, "ctrl_nak");
   endtask
   task automatic t_out_nak;
      i_host.pulse(OUT_OK);
      rd(unc_pkg::INT_STAT_ADDR, 8'h00, "overwrite");
      rd(unc_pkg::CTRL_NAK_ADDR, 8'h02, "ctrl_nak");
      check("nak_out", 8'h01, {7'h00, hs.nak_out});
      wr(unc_pkg::FIFO_CTRL_ADDR, 8'h01);
      #1 check("rx_clear", 8'h01, {7'h00, rx_clear});
      rd(unc_pkg::CTRL_NAK_ADDR, 8'h00, "ctrl_nak");
      i_host.pulse(OUT_OK);
      rd(unc_pkg::CTRL_NAK_ADDR, 8'h02, "ctrl_nak");
      i_host.pulse(RX_EMPTY);
      rd(unc_pkg::CTRL_NAK_ADDR, 8'h00, "ctrl_nak");
   endtask
   task automatic t_clear_defer;
      wr(unc_pkg::NAK_ALL_ADDR, 8'h01);
      i_host.hold(IN_TOK[9:0]);
      wr(unc_pkg::NAK_ALL_ADDR, 8'h00);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h01, "nak_all");
      check("nak_seen", 8'h01, {7'h00, i_host.nak_seen});
      i_host.hold(10'h000);
      repeat (2) @(posedge i_clk);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h00, "nak_all");
      i_host.pulse(SETUP);
      i_host.pulse(BUS_RST);
      wr(unc_pkg::NAK_ALL_ADDR, 8'h01);
      rd(unc_pkg::NAK_ALL_ADDR, 8'h01, "nak_all");
      wr(unc_pkg::NAK_ALL_ADDR, 8'h00);
   endtask

   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // main sequence after a two-cycle reset
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      t_reset();
      t_idle_set();
      t_pend_busy();
      t_auto();
      t_overwrite();
      t_in_ready();
      t_out_nak();
      t_clear_defer();
      report_and_stop();
   end
   // watchdog well beyond the hundred-odd cycles the tests need
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
endmodule
